// file: hw/pcl_core.sv
// Control and status core of a 10/100 transceiver on its MAC side.
// Assumes a 100 MHz clock, classic Wishbone and asynchronous pins.
// Summary of operation
// - EEE leaves hardware reset off and is switched only by the EEE enable bit.
// - EEE runs only in MII, transmit-error pin mode, enabled, advertised, 100 full duplex.
// - EEE capability and advertisement defaults follow the current EEE enable bit.
// - Isolate set ignores transmit enable, error and data; registers stay reachable.
// - Isolate reads zero after power-up.
// - Resets reload registers, exempt bits survive soft reset.
// - Interface runs slow for 16 us after reset, then fast if negotiating.
// - Writing soft reset starts a reset; bit self-clears well within 0.5 s.
// - Carrier sense on CRS or CRS_DV; receive only in repeater or full duplex.
// - Two non-adjacent zeros in any ten code bits raise carrier.
// - Ten ones before the start delimiter pair drop carrier.
// - After start pair, carrier ends on T-R or two idles, dropped early.
// - Collision while transmit and receive overlap, never in full duplex outside collision test.
// - Collision test raises COL within 512, drops within 4 bit times.
// - 100 and 10 Mbps link results merge into link status and LED.
// - Valid line goes to ready, waits negotiation, then up; direct without it.
// - Link monitor waits 330 ms of valid line before ready.
// - Loss of valid line drops link at once and returns to down.
// - In 10 Mbps mode link comes from the 10 Mbps receiver.
`timescale 1ns/1ps
`default_nettype none
module pcl_core #(
  parameter int SETTLE_CYC = pcl_pkg::SETTLE_CYC
) (
  // System
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // MAC transmit pins
  input  wire logic        tx_en_pin,
  input  wire logic        tx_er_pin,
  input  wire logic [3:0]  txd_pin,
  // Receive code stream
  input  wire logic        rx_code_clk,
  input  wire logic        rx_code_bit,
  // Line and negotiation status
  input  wire logic        line_signal_valid,
  input  wire logic        link10_ok,
  input  wire logic        aneg_link_enable,
  // Straps
  input  wire logic        reduced_interface_select_strap,
  input  wire logic        interrupt_pin_select_strap,
  // MAC receive status
  output logic             crs_o,
  output logic             crs_dv_o,
  output logic             col_o,
  // Gated transmit path
  output logic             core_tx_en,
  output logic             core_tx_er,
  output logic      [3:0]  core_txd,
  // Status pins
  output logic             link_indicator_led,
  output logic             eee_active,
  output logic             iface_fast
);

  // Pin synchronisers.
  wire  [pcl_pkg::NSYNC-1:0] async_w;
  wire  [pcl_pkg::NSYNC-1:0] sync_w;

  assign async_w = {rx_code_clk,
                    rx_code_bit,
                    tx_en_pin,
                    tx_er_pin,
                    txd_pin,
                    line_signal_valid,
                    link10_ok,
                    aneg_link_enable,
                    reduced_interface_select_strap,
                    interrupt_pin_select_strap};

  for (genvar g = 0; g < pcl_pkg::NSYNC; g++)
  begin : g_sync
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end
      else
      begin
        s1_reg <= async_w[g];
        s2_reg <= s1_reg;
      end
    end
    assign sync_w[g] = s2_reg;
  end

  // Register state.
  logic [7:0]               ctrl_reg;
  logic [7:0]               ctrl_next;
  logic                     srst_reg;
  logic                     adv_reg;
  logic                     adv_next;
  logic                     ack_reg;
  logic [31:0]              dat_reg;
  logic [1:0]               cap_cnt_reg;
  logic                     rmii_reg;
  logic                     intsel_reg;
  logic [pcl_pkg::WAKE_W-1:0] wake_cnt_reg;
  logic                     rclk_d_reg;
  logic                     col_reg;
  logic                     crs_reg;
  logic                     eee_reg;
  logic                     fast_reg;
  logic                     led_reg;
  logic                     rx_crs;
  logic                     link_ok;

  // Control fields.
  wire iso_w   = ctrl_reg[pcl_pkg::C_ISO];
  wire colt_w  = ctrl_reg[pcl_pkg::C_COLT];
  wire aneg_w  = ctrl_reg[pcl_pkg::C_ANEG];
  wire fdx_w   = ctrl_reg[pcl_pkg::C_FDX];
  wire rpt_w   = ctrl_reg[pcl_pkg::C_RPT];
  wire spd10_w = ctrl_reg[pcl_pkg::C_SPD10];
  wire eee_w   = ctrl_reg[pcl_pkg::C_EEE];

  // Bus decode.
  wire req_w     = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_w      = req_w && wb_we_i && wb_sel_i[0];
  wire hit_ctrl  = wb_adr_i == pcl_pkg::ADR_CTRL;
  wire hit_stat  = wb_adr_i == pcl_pkg::ADR_STAT;
  wire hit_eee   = wb_adr_i == pcl_pkg::ADR_EEE;
  wire wr_ctrl   = wr_w && hit_ctrl;
  wire wr_eee    = wr_w && hit_eee;
  wire srst_go   = wr_ctrl && wb_dat_i[pcl_pkg::C_SRST];

  // Soft reset reloads everything but the exempt bits; power-down has no path here.
  assign ctrl_next = srst_reg ? ((pcl_pkg::CTRL_RST & ~pcl_pkg::SR_KEEP) |
                                 (ctrl_reg & pcl_pkg::SR_KEEP))
                   : wr_ctrl  ? {wb_dat_i[7:1], 1'b0}
                   : ctrl_reg;

  // Advertisement tracks each change of the enable bit, even after software writes it.
  assign adv_next = srst_reg ? eee_w
                  : wr_eee   ? wb_dat_i[pcl_pkg::E_ADV]
                  : (wr_ctrl && wb_dat_i[pcl_pkg::C_EEE] != eee_w) ? wb_dat_i[pcl_pkg::C_EEE]
                  : adv_reg;

  // Read data.
  wire [7:0]  stat_w = {1'b0,
                        col_reg,
                        crs_reg,
                        intsel_reg,
                        rmii_reg,
                        fast_reg,
                        eee_reg,
                        link_ok};
  wire [31:0] rd_w   = hit_ctrl ? {24'h000000, ctrl_reg | {7'h00, srst_reg}}
                     : hit_stat ? {24'h000000, stat_w}
                     : hit_eee  ? {30'h00000000, eee_w, adv_reg}
                     : 32'h00000000;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= pcl_pkg::CTRL_RST;
      adv_reg  <= 1'b0;
      srst_reg <= 1'b0;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h00000000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      adv_reg  <= adv_next;
      srst_reg <= srst_go;
      ack_reg  <= req_w;
      dat_reg  <= req_w ? rd_w : dat_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Straps are taken once the synchronisers hold real pin levels.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cap_cnt_reg <= 2'h0;
      rmii_reg    <= 1'b0;
      intsel_reg  <= 1'b0;
    end
    else if (cap_cnt_reg != 2'h3)
    begin
      cap_cnt_reg <= cap_cnt_reg + 2'h1;
      rmii_reg    <= sync_w[pcl_pkg::Y_RMII];
      intsel_reg  <= sync_w[pcl_pkg::Y_INTSEL];
    end
  end

  // Interface speed after reset.
  wire wake_done = wake_cnt_reg == pcl_pkg::WAKE_W'(pcl_pkg::WAKE_CYC);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_cnt_reg <= '0;
    else if (srst_reg)
      wake_cnt_reg <= '0;
    else if (!wake_done)
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
  end

  // Transmit path, carrier and collision.
  wire tx_act    = sync_w[pcl_pkg::Y_TXEN] && !iso_w;
  wire rx_tick   = sync_w[pcl_pkg::Y_RCLK] && !rclk_d_reg;
  wire rx_only   = rpt_w || fdx_w;
  wire crs_w     = rx_crs || (!rx_only && tx_act);
  wire col_w     = colt_w ? tx_act : (!fdx_w && tx_act && rx_crs);
  wire eee_ok    = !rmii_reg && !intsel_reg && eee_w && adv_reg &&
                   link_ok && fdx_w && !spd10_w;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rclk_d_reg <= 1'b0;
      col_reg    <= 1'b0;
      crs_reg    <= 1'b0;
      eee_reg    <= 1'b0;
      fast_reg   <= 1'b0;
      led_reg    <= 1'b0;
      core_tx_en <= 1'b0;
      core_tx_er <= 1'b0;
      core_txd   <= 4'h0;
      crs_o      <= 1'b0;
      crs_dv_o   <= 1'b0;
    end
    else
    begin
      rclk_d_reg <= sync_w[pcl_pkg::Y_RCLK];
      col_reg    <= col_w;
      crs_reg    <= crs_w;
      eee_reg    <= eee_ok;
      fast_reg   <= wake_done && aneg_w;
      led_reg    <= link_ok;
      core_tx_en <= tx_act;
      core_tx_er <= sync_w[pcl_pkg::Y_TXER] && !iso_w;
      core_txd   <= iso_w ? 4'h0 : sync_w[8:5];
      crs_o      <= !rmii_reg && crs_w;
      crs_dv_o   <= rmii_reg && crs_w;
    end
  end

  assign col_o              = col_reg;
  assign eee_active         = eee_reg;
  assign iface_fast         = fast_reg;
  assign link_indicator_led = led_reg;

  pcl_carrier u_carrier (
    .clock     (clock),
    .rst       (rst),
    .clr       (srst_reg),
    .bit_valid (rx_tick),
    .bit_in    (sync_w[pcl_pkg::Y_RBIT]),
    .crs       (rx_crs)
  );

  pcl_link #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_link (
    .clock   (clock),
    .rst     (rst),
    .clr     (srst_reg),
    .valid   (sync_w[pcl_pkg::Y_VALID]),
    .aneg_en (aneg_w),
    .aneg_ok (sync_w[pcl_pkg::Y_ANOK]),
    .speed10 (spd10_w),
    .link10  (sync_w[pcl_pkg::Y_LINK10]),
    .link    (link_ok)
  );

  // Checks.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence tx_rise_s;
    $rose(tx_act) && colt_w;
  endsequence

  sequence tx_fall_s;
    $fell(tx_act) && colt_w;
  endsequence

  chk_eee_gate: assert property (eee_active |-> !rmii_reg && !intsel_reg &&
    $past(fdx_w) && $past(adv_reg)) else $error("EEE active outside its conditions");

  chk_adv_default: assert property (srst_reg |=> adv_reg == $past(eee_w))
    else $error("advertisement default not taken from enable");

  chk_iso_tx: assert property (iso_w |=> !core_tx_en && core_txd == 4'h0)
    else $error("transmit passed while isolated");

  chk_srst_clear: assert property (srst_reg |=> !srst_reg && !iso_w && !colt_w)
    else $error("soft reset did not clear");

  chk_wake_slow: assert property (!wake_done |=> !iface_fast)
    else $error("interface fast before wake time");

  chk_col_fdx: assert property (fdx_w && !colt_w |=> !col_o)
    else $error("collision shown in full duplex");

  chk_coltest_on: assert property (tx_rise_s ##1 colt_w |-> ##[0:3] col_o)
    else $error("collision test late on rise");

  chk_coltest_off: assert property (tx_fall_s |-> ##[0:3] !col_o)
    else $error("collision test late on fall");

  chk_crs_rx: assert property (rx_only && !rx_crs |=> !crs_o && !crs_dv_o)
    else $error("carrier from transmit in receive-only mode");

  chk_iso_answer: assert property (req_w && iso_w |=> wb_ack_o)
    else $error("no bus answer while isolated");

  chk_crs_pin: assert property (rmii_reg |=> !crs_o)
    else $error("MII carrier pin driven in RMII mode");

  chk_crs_dv_pin: assert property (!rmii_reg |=> !crs_dv_o)
    else $error("RMII carrier pin driven in MII mode");

  chk_fast_aneg: assert property (!aneg_w |=> !iface_fast)
    else $error("interface fast without negotiation");

  chk_adv_copy: assert property (wr_ctrl && wb_dat_i[pcl_pkg::C_EEE] != eee_w |=>
    adv_reg == eee_w) else $error("advertisement did not follow enable");

endmodule : pcl_core
`default_nettype wire

// file: hw/pcl_pkg.sv
// Constants shared by the carrier, collision and link control core.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
package pcl_pkg;
  localparam int         CLK_MHZ    = 100;
  localparam int         WAKE_US    = 16;
  localparam int         WAKE_CYC   = WAKE_US * CLK_MHZ;
  localparam int         WAKE_W     = $clog2(WAKE_CYC + 1);
  localparam int         SETTLE_MS  = 330;
  localparam int         SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STAT   = 8'h04;
  localparam logic [7:0] ADR_EEE    = 8'h08;
  // Control register fields.
  localparam int         C_SRST     = 0;
  localparam int         C_ISO      = 1;
  localparam int         C_COLT     = 2;
  localparam int         C_ANEG     = 3;
  localparam int         C_FDX      = 4;
  localparam int         C_RPT      = 5;
  localparam int         C_SPD10    = 6;
  localparam int         C_EEE      = 7;
  localparam logic [7:0] CTRL_RST   = 8'h08;
  // Bits that survive a soft reset.
  localparam logic [7:0] SR_KEEP    = 8'h80;
  // EEE register fields.
  localparam int         E_ADV      = 0;
  localparam int         E_CAP      = 1;
  // Sync vector positions.
  localparam int         Y_RCLK     = 12;
  localparam int         Y_RBIT     = 11;
  localparam int         Y_TXEN     = 10;
  localparam int         Y_TXER     = 9;
  localparam int         Y_VALID    = 4;
  localparam int         Y_LINK10   = 3;
  localparam int         Y_ANOK     = 2;
  localparam int         Y_RMII     = 1;
  localparam int         Y_INTSEL   = 0;
  localparam int         NSYNC      = 13;
  // Code groups, first received bit in the MSB.
  localparam logic [4:0] SYM_J      = 5'h18;
  localparam logic [4:0] SYM_K      = 5'h11;
  localparam logic [4:0] SYM_T      = 5'h0D;
  localparam logic [4:0] SYM_R      = 5'h07;
  localparam logic [4:0] SYM_I      = 5'h1F;
  localparam logic [9:0] ALL_ONES   = 10'h3FF;
  typedef enum logic [1:0] {CS_IDLE, CS_SENSE, CS_STREAM, CS_END} pcl_cs_t;
  typedef enum logic [1:0] {LK_DOWN, LK_SETTLE, LK_READY, LK_UP} pcl_lk_t;
endpackage : pcl_pkg

// file: hw/pcl_carrier.sv
// Carrier detector working on the encoded, unscrambled receive bits.
// Assumes one bit_valid pulse per received code bit.
`timescale 1ns/1ps
`default_nettype none
module pcl_carrier (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clr,
  // Code bits
  input  wire logic bit_valid,
  input  wire logic bit_in,
  // Result
  output logic      crs
);
  logic [9:0]       win_reg;
  logic [2:0]       cnt_reg;
  logic             pend_t_reg;
  pcl_pkg::pcl_cs_t st_reg;
  pcl_pkg::pcl_cs_t st_next;
  wire  [9:0]       win_w    = {win_reg[8:0], bit_in};
  wire  [4:0]       sym_w    = win_w[4:0];
  wire              sym_done = bit_valid && cnt_reg == 3'h4;

  function automatic logic two_zeros(input logic [9:0] w);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int j = i + 2; j < 10; j++)
        if (!w[i] && !w[j])
          f = 1'b1;
    return f;
  endfunction : two_zeros

  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      pcl_pkg::CS_IDLE:   if (bit_valid && two_zeros(win_w)) st_next = pcl_pkg::CS_SENSE;
      pcl_pkg::CS_SENSE:
        if (bit_valid && win_w == pcl_pkg::ALL_ONES) st_next = pcl_pkg::CS_IDLE;
        else if (bit_valid && win_w == {pcl_pkg::SYM_J, pcl_pkg::SYM_K})
          st_next = pcl_pkg::CS_STREAM;
      pcl_pkg::CS_STREAM:
        if (sym_done && (sym_w == pcl_pkg::SYM_T || sym_w == pcl_pkg::SYM_I))
          st_next = pcl_pkg::CS_END;
      pcl_pkg::CS_END:
        if (sym_done)
          st_next = ((pend_t_reg && sym_w == pcl_pkg::SYM_R) ||
                     (!pend_t_reg && sym_w == pcl_pkg::SYM_I)) ? pcl_pkg::CS_IDLE
                                                               : pcl_pkg::CS_STREAM;
    endcase
    if (clr)
      st_next = pcl_pkg::CS_IDLE;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_reg     <= pcl_pkg::CS_IDLE;
      win_reg    <= 10'h3FF;
      cnt_reg    <= 3'h0;
      pend_t_reg <= 1'b0;
      crs        <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      // The delimiter bits are flushed at stream end so they cannot raise carrier again.
      win_reg    <= (clr || (st_reg == pcl_pkg::CS_END && st_next == pcl_pkg::CS_IDLE))
                    ? pcl_pkg::ALL_ONES : bit_valid ? win_w : win_reg;
      cnt_reg    <= (st_reg == pcl_pkg::CS_SENSE || sym_done) ? 3'h0 : cnt_reg + 3'(bit_valid);
      pend_t_reg <= (st_next == pcl_pkg::CS_END && st_reg == pcl_pkg::CS_STREAM)
                    ? sym_w == pcl_pkg::SYM_T : pend_t_reg;
      crs        <= st_next == pcl_pkg::CS_SENSE || st_next == pcl_pkg::CS_STREAM;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_ones_drop: assert property (st_reg == pcl_pkg::CS_SENSE && bit_valid && !clr &&
    win_w == pcl_pkg::ALL_ONES |=> !crs) else $error("carrier kept after ten ones");
endmodule : pcl_carrier
`default_nettype wire

// file: hw/pcl_link.sv
// Link monitor for the 100 Mbps path, merged with the 10 Mbps result.
// Assumes synchronised status inputs on the system clock.
`timescale 1ns/1ps
`default_nettype none
module pcl_link #(
  parameter int SETTLE_CYC = pcl_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clr,
  // Status in
  input  wire logic valid,
  input  wire logic aneg_en,
  input  wire logic aneg_ok,
  input  wire logic speed10,
  input  wire logic link10,
  // Result
  output logic      link
);
  localparam int    CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    vrun_reg;
  pcl_pkg::pcl_lk_t st_reg;
  pcl_pkg::pcl_lk_t st_next;

  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      pcl_pkg::LK_DOWN:   st_next = pcl_pkg::LK_SETTLE;
      pcl_pkg::LK_SETTLE: if (cnt_reg == LAST)
          st_next = aneg_en ? pcl_pkg::LK_READY : pcl_pkg::LK_UP;
      pcl_pkg::LK_READY:  if (aneg_ok || !aneg_en) st_next = pcl_pkg::LK_UP;
      pcl_pkg::LK_UP:     st_next = pcl_pkg::LK_UP;
    endcase
    if (!valid || clr)
      st_next = pcl_pkg::LK_DOWN;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_reg   <= pcl_pkg::LK_DOWN;
      cnt_reg  <= '0;
      vrun_reg <= '0;
      link     <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= (st_reg == pcl_pkg::LK_SETTLE) ? cnt_reg + 1'b1 : '0;
      vrun_reg <= (!valid || clr) ? '0 : (vrun_reg == LAST + 1'b1) ? vrun_reg : vrun_reg + 1'b1;
      link     <= speed10 ? link10 : st_next == pcl_pkg::LK_UP;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_link_drop: assert property (!valid && !speed10 |=> !link)
    else $error("link kept while line not valid");
  chk_settle_wait: assert property (st_reg == pcl_pkg::LK_READY ||
    st_reg == pcl_pkg::LK_UP |-> vrun_reg > LAST) else $error("link ready before settle time");
endmodule : pcl_link
`default_nettype wire

// file: tb/pcl_line_model.sv
// Receive line model: serialises encoded code bits on a gated 160 ns code clock.
// Assumes the core takes a bit on the rising edge of the code clock.
`timescale 1ns/1ps
`default_nettype none
module pcl_line_model (
  // Code stream
  output logic rx_code_clk,
  output logic rx_code_bit
);
  initial
  begin
    rx_code_clk = 1'b0;
    rx_code_bit = 1'b1;
  end

  // The clock stands still between frames. The bit is inverted afterwards so that a
  // stale level is never taken for data.
  task automatic send(input logic [39:0] b, input int n);
    #3;
    for (int i = n - 1; i >= 0; i--)
    begin
      rx_code_bit = b[i];
      #80 rx_code_clk = 1'b1;
      #80 rx_code_clk = 1'b0;
    end
    rx_code_bit = ~rx_code_bit;
  endtask : send
endmodule : pcl_line_model
`default_nettype wire

// file: tb/pcl_core_test.sv
// Self-checking bench for the carrier, collision and link control core.
// Assumes the receive line model beside the core and SETTLE_CYC shortened to 50.
`timescale 1ns/1ps
`default_nettype none
module pcl_core_test;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic        tx_en = 1'b0;
  logic        tx_er = 1'b0;
  logic [3:0]  txd = 4'h0;
  logic        valid = 1'b0;
  logic        l10 = 1'b0;
  logic        an_ok = 1'b0;
  logic        rmii = 1'b0;
  logic        isel = 1'b0;
  logic [16:0] seed = 17'h12365;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic        rclk, rbit, ack, crs, crs_dv, col, c_en, c_er, led, eee, fast;
  logic [31:0] dat_o;
  logic [3:0]  c_txd;

  always #5 clock = ~clock;
  always @(posedge clock) cycles <= cycles + 1;

  pcl_line_model pcl_line_model_inst (.rx_code_clk(rclk), .rx_code_bit(rbit));

  pcl_core #(.SETTLE_CYC(50)) pcl_core_inst (
    .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_en_pin(tx_en), .tx_er_pin(tx_er), .txd_pin(txd), .rx_code_clk(rclk),
    .rx_code_bit(rbit), .line_signal_valid(valid), .link10_ok(l10),
    .aneg_link_enable(an_ok), .reduced_interface_select_strap(rmii),
    .interrupt_pin_select_strap(isel), .crs_o(crs), .crs_dv_o(crs_dv), .col_o(col),
    .core_tx_en(c_en), .core_tx_er(c_er), .core_txd(c_txd),
    .link_indicator_led(led), .eee_active(eee), .iface_fast(fast)
  );

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  // Both straps must be low; the advertisement follows the enable in every scenario.
  function automatic logic exp_eee(input logic [7:0] c, input logic lk, input logic rm,
                                   input logic is);
    return c[7] & c[4] & ~c[6] & lk & ~rm & ~is;
  endfunction : exp_eee

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cb(input logic got, input logic exp, input string m);
    chk(32'(got), 32'(exp), m);
  endtask : cb

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock);
    cb(ack, 1'b0, "ack held past one cycle");
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
      @(posedge clock);
    while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  initial
  begin
    #300000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    tick(10);
    rst <= 1'b0;
    wb(1'b0, pcl_pkg::ADR_CTRL, 32'h0, rd);
    chk(rd, 32'h08, "control after reset");
    cb(eee, 1'b0, "eee after reset");
    cb(fast, 1'b0, "fast interface too early");
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    // Transmit pins are ignored while isolated, yet registers still answer.
    seed = lfsr(seed);
    tx_en <= 1'b1;
    tx_er <= 1'b1;
    txd   <= seed[3:0];
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h0A, rd);
    tick(5);
    chk(32'({c_en, c_er, c_txd}), 32'h0, "isolated transmit");
    wb(1'b0, pcl_pkg::ADR_CTRL, 32'h0, rd);
    chk(rd, 32'h0A, "control while isolated");
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h08, rd);
    tick(5);
    chk(32'({c_en, c_er, c_txd}), 32'({2'b11, seed[3:0]}), "transmit path");
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h1C, rd);
    tx_en <= 1'b1;
    tick(6);
    cb(col, 1'b1, "collision test on");
    tx_en <= 1'b0;
    tick(6);
    cb(col, 1'b0, "collision test off");
    // Half duplex, full duplex, then repeater mode.
    for (int d = 0; d < 3; d++)
    begin
      wb(1'b1, pcl_pkg::ADR_CTRL, d == 0 ? 32'h08 : d == 1 ? 32'h18 : 32'h28, rd);
      tx_en <= 1'b1;
      tick(5);
      cb(crs, d == 0, "carrier from transmit");
      pcl_line_model_inst.send(40'({pcl_pkg::SYM_J, pcl_pkg::SYM_K, 5'h1E}), 15);
      tick(6);
      cb(col, d != 1, "collision");
      tx_en <= 1'b0;
      tick(6);
      cb(crs, 1'b1, "carrier in stream");
      pcl_line_model_inst.send(40'({pcl_pkg::SYM_T, pcl_pkg::SYM_R}), 10);
      tick(6);
      cb(crs, 1'b0, "carrier after end pair");
    end
    pcl_line_model_inst.send(40'h0B, 5);
    tick(6);
    cb(crs, 1'b1, "two spaced zeros");
    pcl_line_model_inst.send(40'(pcl_pkg::ALL_ONES), 10);
    tick(6);
    cb(crs, 1'b0, "ten ones");
    pcl_line_model_inst.send(40'({pcl_pkg::SYM_J, pcl_pkg::SYM_K, pcl_pkg::SYM_T, 5'h1E}), 20);
    tick(6);
    cb(crs, 1'b1, "end without R");
    pcl_line_model_inst.send(40'({pcl_pkg::SYM_I, pcl_pkg::SYM_I}), 10);
    tick(6);
    cb(crs, 1'b0, "two idles");
    while (cycles < 1700)
      tick(1);
    cb(fast, 1'b1, "fast interface");
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h90, rd);
    wb(1'b0, pcl_pkg::ADR_EEE, 32'h0, rd);
    chk(rd, 32'h3, "eee defaults");
    valid <= 1'b1;
    tick(30);
    cb(led, 1'b0, "link before settle");
    tick(40);
    cb(led, 1'b1, "link without negotiation");
    cb(eee, exp_eee(8'h90, 1'b1, rmii, isel), "eee running");
    valid <= 1'b0;
    tick(5);
    cb(led, 1'b0, "link lost");
    seed = lfsr(seed);
    l10 <= seed[0];
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'hD0, rd);
    tick(6);
    cb(led, seed[0], "ten megabit link");
    cb(eee, exp_eee(8'hD0, led, rmii, isel), "eee at ten megabit");
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h18, rd);
    valid <= 1'b1;
    tick(70);
    cb(led, 1'b0, "link ready waits");
    an_ok <= 1'b1;
    tick(6);
    cb(led, 1'b1, "link granted");
    wb(1'b0, pcl_pkg::ADR_STAT, 32'h0, rd);
    chk(rd & 32'h1, 32'h1, "link status bit");
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h85, rd);
    tick(3);
    wb(1'b0, pcl_pkg::ADR_CTRL, 32'h0, rd);
    chk(rd, 32'h88, "control after soft reset");
    wb(1'b0, pcl_pkg::ADR_EEE, 32'h0, rd);
    chk(rd, 32'h3, "eee after soft reset");
    // Second hardware reset with both straps high: RMII carrier pin and no EEE.
    rmii <= 1'b1;
    isel <= 1'b1;
    rst  <= 1'b1;
    tick(3);
    rst  <= 1'b0;
    tick(4);
    cb(led | eee | fast | crs | crs_dv | col | c_en, 1'b0, "outputs after reset");
    wb(1'b0, pcl_pkg::ADR_STAT, 32'h0, rd);
    chk(rd & 32'h18, 32'h18, "straps in status");
    wb(1'b0, pcl_pkg::ADR_CTRL, 32'h0, rd);
    chk(rd, 32'h08, "control after hardware reset");
    wb(1'b0, pcl_pkg::ADR_EEE, 32'h0, rd);
    chk(rd, 32'h0, "eee after hardware reset");
    tx_en <= 1'b1;
    tick(5);
    cb(crs, 1'b0, "MII carrier in RMII mode");
    cb(crs_dv, 1'b1, "RMII carrier");
    tx_en <= 1'b0;
    wb(1'b1, pcl_pkg::ADR_CTRL, 32'h90, rd);
    tick(70);
    cb(led, 1'b1, "link after hardware reset");
    cb(eee, exp_eee(8'h90, led, rmii, isel), "eee in RMII mode");
    end_of_test();
  end
endmodule : pcl_core_test
`default_nettype wire
